// file: design/ewk_params.svh
`ifndef EWK_PARAMS_SVH
`define EWK_PARAMS_SVH

`define EWK_NSRC        3
`define EWK_ADDR_CFG    32'h4004C080
`define EWK_ADDR_STAT   32'h4004C084
`define EWK_ADDR_CLR    32'h4004C090
`define EWK_ADDR_NMICLR 32'h4004C094
`define EWK_ADDR_AIEN   32'h400C0A28
`define EWK_ADDR_ISTAT  32'h4004C0A0
`define EWK_ADDR_IMASK  32'h4004C0A4

`define EWK_CFG_RST     32'h00200000
`define EWK_CFG_MASK    32'h00F0F0F0
`define EWK_ZERO32      32'h00000000
`define EWK_AIEN_MASK   32'h0000000F

`define EWK_ST_RX       5
`define EWK_ST_EXT_IRQ_THREE_CLEAR     3
`define EWK_ST_EXT_IRQ_ONE_CLEAR     1
`define EWK_CL_RX       5
`define EWK_CL_EXT_IRQ_THREE_CLEAR     4
`define EWK_CL_EXT_IRQ_ONE_CLEAR     1
`define EWK_CL_NMI      0
`define EWK_AIEN_WAKE   3

`define EWK_EN_EXT_IRQ_ONE_CLEAR     7
`define EWK_EN_EXT_IRQ_THREE_CLEAR     15
`define EWK_EN_RX       20
`define EWK_MD_EXT_IRQ_ONE_CLEAR     4
`define EWK_MD_EXT_IRQ_THREE_CLEAR     12
`define EWK_MD_RX       21

`define EWK_MODE_RISE   3'h0
`define EWK_MODE_FALL   3'h1
`define EWK_MODE_BOTH   3'h2
`define EWK_MODE_HIGH   3'h3
`define EWK_MODE_LOW    3'h4

`endif

// file: design/ewk_pkg.sv
package ewk_pkg;
    typedef enum logic {EWK_IDLE, EWK_ACK} ewk_bus_st_t;
    typedef logic [2:0] ewk_mode_t;
endpackage : ewk_pkg

// file: design/ewk_evt_if.sv
`timescale 1ns/1ns
interface ewk_evt_if;
    logic pulse;
    logic level;
    modport src (output pulse, output level);
    modport dst (input pulse, input level);
endinterface : ewk_evt_if

// file: design/ewk_detect.sv
`timescale 1ns/1ns
`include "ewk_params.svh"
module ewk_detect import ewk_pkg::*; (
    input  wire logic      sys_clk_in, // Core clock
    input  wire logic      nrst_in,    // Sync reset, active low
    input  wire logic      pin_in,     // Asynchronous source
    input  wire logic      en_in,      // Source enable
    input  wire ewk_mode_t mode_in,    // Detect mode
    ewk_evt_if.src         evt         // Trigger pulse and level
);
    logic sync1_ff, sync2_ff, prev_ff, hit_ff;
    logic nxt_sync1, nxt_sync2, nxt_prev, nxt_hit;

    always_comb begin
        nxt_sync1 = pin_in;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
        case (mode_in)
            `EWK_MODE_RISE: nxt_hit = sync2_ff & ~prev_ff;
            `EWK_MODE_LOW:  nxt_hit = ~sync2_ff;
            3'h1, 3'h5:     nxt_hit = ~sync2_ff & prev_ff;
            3'h2, 3'h6:     nxt_hit = sync2_ff ^ prev_ff;
            default:        nxt_hit = sync2_ff;
        endcase
        nxt_hit = nxt_hit & en_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
            hit_ff   <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
            hit_ff   <= nxt_hit;
        end
    end

    assign evt.pulse = hit_ff;
    assign evt.level = sync2_ff;

    en_gate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !en_in |=> !hit_ff) else $error("disabled source raised a trigger");
    rise_det_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (en_in && mode_in == `EWK_MODE_RISE && sync2_ff && !prev_ff) |=> hit_ff)
        else $error("rising edge missed");
endmodule : ewk_detect

// file: design/ewk_sticky.sv
`timescale 1ns/1ns
module ewk_sticky #(
    parameter int WIDTH = 3
) (
    input  wire logic             sys_clk_in, // Core clock
    input  wire logic             nrst_in,    // Sync reset, active low
    input  wire logic [WIDTH-1:0] set_in,     // Hardware set
    input  wire logic [WIDTH-1:0] clr_in,     // Clear request
    output logic      [WIDTH-1:0] q_out       // Flags
);
    if (WIDTH < 1) begin : g_chk
        $error("ewk_sticky needs WIDTH of at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic q_ff, nxt_q;
        always_comb begin
            nxt_q = set_in[i] | (q_ff & ~clr_in[i]);
        end
        always_ff @(posedge sys_clk_in) begin
            if (!nrst_in) begin
                q_ff <= 1'b0;
            end else begin
                q_ff <= nxt_q;
            end
        end
        assign q_out[i] = q_ff;
    end
endmodule : ewk_sticky

// file: design/ewk_top.sv
`timescale 1ns/1ns
`include "ewk_params.svh"

// Overview of operation
// - Serial-receive wake event sets status bit 5; otherwise it reads 0.
// - Status bit 5 is read-only; only clear-register bit 5 clears it.
// - External interrupt 3 event sets status bit 3.
// - Status bit 3 is valid only while the inter-die line is asserted.
// - External interrupt 1 on the system wake pin sets status bit 1.
// - Status bit 1 is read-only; only clear-register bit 1 clears it.
// - Writing 1 to clear bit 5 clears serial wake flag; bit self-clears.
// - Writing 1 to clear bit 4 clears interrupt 3 flag; bit self-clears.
// - Writing 1 to clear bit 1 clears interrupt 1 flag; bit self-clears.
// - Writing 1 to nonmaskable clear bit 0 clears pending NMI; self-clears.
// - Enable bit 3 lets any analog die access wake the front end.
// - Status resets to zero; reserved bits read zero.
// - Serial, interrupt 1 and interrupt 3 sources set flags only while their enable bits are 1; NMI has no enable.
// - Mode field picks rising, falling, either edge, high or low level.
module ewk_top import ewk_pkg::*; (
    input  wire logic        sys_clk_in,             // Core clock, 100 MHz
    input  wire logic        nrst_in,                // Sync reset, active low
    input  wire logic [31:0] avs_address_in,         // Byte address
    input  wire logic        avs_read_in,            // Read request
    input  wire logic        avs_write_in,           // Write request
    input  wire logic [31:0] avs_writedata_in,       // Write data
    input  wire logic [3:0]  avs_byteenable_in,      // Byte lanes
    output logic      [31:0] avs_readdata_out,       // Read data
    output logic             avs_waitrequest_out,    // Stall
    input  wire logic        system_wake_pin_in,     // Interrupt 1 pin
    input  wire logic        serial_receive_pin_in,  // Serial wake pin
    input  wire logic        inter_die_interrupt_in, // Interrupt 3 line
    input  wire logic        nmi_in,                 // NMI source level
    input  wire logic        die_access_in,          // Analog die access
    output logic             afe_wake_out,           // Front-end wake
    output logic             nmi_pending_out,        // NMI pending
    output logic             irq_out                 // Masked event irq
);
    localparam int NS = `EWK_NSRC;

    ewk_bus_st_t st_ff, nxt_st;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] cfg_ff, nxt_cfg;
    logic [31:0] imask_ff, nxt_imask;
    logic [31:0] aien_ff, nxt_aien;
    logic [31:0] clr_ff, nxt_clr;
    logic        nmiclr_ff, nxt_nmiclr;
    logic        afe_wake_ff, nxt_afe_wake;
    logic        nmi_s1_ff, nmi_s2_ff, nmi_prev_ff;
    logic        nmi_flag_ff, nxt_nmi_flag;

    logic [31:0] wmask, stat_rd, istat_rd;
    logic        go, wr_go;
    logic [NS-1:0] src_pin, src_en, evt, flag_clr, flag, istat, istat_clr;
    ewk_mode_t   src_mode [NS];

    // Source order: 0 interrupt 1, 1 interrupt 3, 2 serial receive
    assign src_pin  = {serial_receive_pin_in, inter_die_interrupt_in,
                       system_wake_pin_in};
    assign src_en   = {cfg_ff[`EWK_EN_RX], cfg_ff[`EWK_EN_EXT_IRQ_THREE_CLEAR],
                       cfg_ff[`EWK_EN_EXT_IRQ_ONE_CLEAR]};
    assign src_mode[0] = cfg_ff[`EWK_MD_EXT_IRQ_ONE_CLEAR +: 3];
    assign src_mode[1] = cfg_ff[`EWK_MD_EXT_IRQ_THREE_CLEAR +: 3];
    assign src_mode[2] = cfg_ff[`EWK_MD_RX +: 3];

    ewk_evt_if evt_if [NS] ();

    for (genvar g = 0; g < NS; g++) begin : g_src
        ewk_detect u_det (
            .sys_clk_in (sys_clk_in),
            .nrst_in    (nrst_in),
            .pin_in     (src_pin[g]),
            .en_in      (src_en[g]),
            .mode_in    (src_mode[g]),
            .evt        (evt_if[g])
        );
        assign evt[g] = evt_if[g].pulse;
    end

    // Clear strobes act one cycle after the write is taken
    assign flag_clr = {clr_ff[`EWK_CL_RX], clr_ff[`EWK_CL_EXT_IRQ_THREE_CLEAR],
                       clr_ff[`EWK_CL_EXT_IRQ_ONE_CLEAR]};

    ewk_sticky #(.WIDTH(NS)) u_flags (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .set_in     (evt),
        .clr_in     (flag_clr),
        .q_out      (flag)
    );

    ewk_sticky #(.WIDTH(NS)) u_istat (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .set_in     (evt),
        .clr_in     (istat_clr),
        .q_out      (istat)
    );

    // Bit 3 means nothing once the inter-die line drops
    always_comb begin
        stat_rd = `EWK_ZERO32;
        stat_rd[`EWK_ST_RX]   = flag[2];
        stat_rd[`EWK_ST_EXT_IRQ_THREE_CLEAR] = flag[1] & evt_if[1].level;
        stat_rd[`EWK_ST_EXT_IRQ_ONE_CLEAR] = flag[0];
        istat_rd = `EWK_ZERO32;
        istat_rd[`EWK_ST_RX]   = istat[2];
        istat_rd[`EWK_ST_EXT_IRQ_THREE_CLEAR] = istat[1];
        istat_rd[`EWK_ST_EXT_IRQ_ONE_CLEAR] = istat[0];
    end

    // One wait state per access
    assign go    = avs_read_in | avs_write_in;
    assign wr_go = avs_write_in & (st_ff == EWK_ACK);
    assign avs_waitrequest_out = go & (st_ff == EWK_IDLE);
    assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    assign istat_clr = (wr_go && avs_address_in == `EWK_ADDR_ISTAT) ?
                       {(avs_writedata_in[`EWK_ST_RX] & wmask[`EWK_ST_RX]),
                        (avs_writedata_in[`EWK_ST_EXT_IRQ_THREE_CLEAR] & wmask[`EWK_ST_EXT_IRQ_THREE_CLEAR]),
                        (avs_writedata_in[`EWK_ST_EXT_IRQ_ONE_CLEAR] & wmask[`EWK_ST_EXT_IRQ_ONE_CLEAR])}
                       : '0;

    always_comb begin
        nxt_st    = st_ff;
        nxt_rdata = rdata_ff;
        case (st_ff)
            EWK_IDLE: begin
                if (go) begin
                    nxt_st = EWK_ACK;
                    case (avs_address_in)
                        `EWK_ADDR_CFG:    nxt_rdata = cfg_ff;
                        `EWK_ADDR_STAT:   nxt_rdata = stat_rd;
                        `EWK_ADDR_CLR:    nxt_rdata = clr_ff;
                        `EWK_ADDR_NMICLR: nxt_rdata = {31'h00000000, nmiclr_ff};
                        `EWK_ADDR_AIEN:   nxt_rdata = aien_ff;
                        `EWK_ADDR_ISTAT:  nxt_rdata = istat_rd;
                        `EWK_ADDR_IMASK:  nxt_rdata = imask_ff;
                        default:          nxt_rdata = `EWK_ZERO32;
                    endcase
                end
            end
            EWK_ACK: nxt_st = EWK_IDLE;
            default: nxt_st = EWK_IDLE;
        endcase
    end

    // Writes land only on the edge that sees waitrequest low
    always_comb begin
        nxt_cfg    = cfg_ff;
        nxt_imask  = imask_ff;
        nxt_aien   = aien_ff;
        nxt_clr    = `EWK_ZERO32;
        nxt_nmiclr = 1'b0;
        if (wr_go) begin
            case (avs_address_in)
                `EWK_ADDR_CFG: nxt_cfg = ((cfg_ff & ~wmask) |
                    (avs_writedata_in & wmask)) & `EWK_CFG_MASK;
                `EWK_ADDR_IMASK: nxt_imask = ((imask_ff & ~wmask) |
                    (avs_writedata_in & wmask)) & istat_rd_mask();
                `EWK_ADDR_AIEN: nxt_aien = ((aien_ff & ~wmask) |
                    (avs_writedata_in & wmask)) & `EWK_AIEN_MASK;
                `EWK_ADDR_CLR: begin
                    nxt_clr = `EWK_ZERO32;
                    nxt_clr[`EWK_CL_RX]   = avs_writedata_in[`EWK_CL_RX] &
                                            wmask[`EWK_CL_RX];
                    nxt_clr[`EWK_CL_EXT_IRQ_THREE_CLEAR] = avs_writedata_in[`EWK_CL_EXT_IRQ_THREE_CLEAR] &
                                            wmask[`EWK_CL_EXT_IRQ_THREE_CLEAR];
                    nxt_clr[`EWK_CL_EXT_IRQ_ONE_CLEAR] = avs_writedata_in[`EWK_CL_EXT_IRQ_ONE_CLEAR] &
                                            wmask[`EWK_CL_EXT_IRQ_ONE_CLEAR];
                end
                `EWK_ADDR_NMICLR: nxt_nmiclr = avs_writedata_in[`EWK_CL_NMI] &
                                               wmask[`EWK_CL_NMI];
                default: nxt_clr = `EWK_ZERO32; // status writes ignored
            endcase
        end
    end

    function automatic logic [31:0] istat_rd_mask();
        logic [31:0] m;
        m = `EWK_ZERO32;
        m[`EWK_ST_RX]   = 1'b1;
        m[`EWK_ST_EXT_IRQ_THREE_CLEAR] = 1'b1;
        m[`EWK_ST_EXT_IRQ_ONE_CLEAR] = 1'b1;
        return m;
    endfunction : istat_rd_mask

    // NMI clear acts only while the NMI is pending; set wins
    always_comb begin
        nxt_nmi_flag = (nmi_s2_ff & ~nmi_prev_ff) |
                       (nmi_flag_ff & ~(nmiclr_ff & nmi_flag_ff));
        nxt_afe_wake = aien_ff[`EWK_AIEN_WAKE] & die_access_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_ff       <= EWK_IDLE;
            rdata_ff    <= `EWK_ZERO32;
            cfg_ff      <= `EWK_CFG_RST;
            imask_ff    <= `EWK_ZERO32;
            aien_ff     <= `EWK_ZERO32;
            clr_ff      <= `EWK_ZERO32;
            nmiclr_ff   <= 1'b0;
            afe_wake_ff <= 1'b0;
            nmi_s1_ff   <= 1'b0;
            nmi_s2_ff   <= 1'b0;
            nmi_prev_ff <= 1'b0;
            nmi_flag_ff <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            rdata_ff    <= nxt_rdata;
            cfg_ff      <= nxt_cfg;
            imask_ff    <= nxt_imask;
            aien_ff     <= nxt_aien;
            clr_ff      <= nxt_clr;
            nmiclr_ff   <= nxt_nmiclr;
            afe_wake_ff <= nxt_afe_wake;
            nmi_s1_ff   <= nmi_in;
            nmi_s2_ff   <= nmi_s1_ff;
            nmi_prev_ff <= nmi_s2_ff;
            nmi_flag_ff <= nxt_nmi_flag;
        end
    end

    assign avs_readdata_out = rdata_ff;
    assign afe_wake_out     = afe_wake_ff;
    assign nmi_pending_out  = nmi_flag_ff;
    assign irq_out          = |(istat_rd & imask_ff);

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    flag_set_a: assert property (evt[0] |=> flag[0])
        else $error("interrupt 1 flag not set");
    rx_set_a: assert property (evt[2] |=> stat_rd[`EWK_ST_RX])
        else $error("serial wake flag not set");
    set_wins_a: assert property ((evt[1] && flag_clr[1]) |=> flag[1])
        else $error("clear beat a same-cycle set");
    ext_irq_one_clear_clr_a: assert property (
        (wr_go && avs_address_in == `EWK_ADDR_CLR && avs_writedata_in[`EWK_CL_EXT_IRQ_ONE_CLEAR]
         && avs_byteenable_in[0]) |=> clr_ff[`EWK_CL_EXT_IRQ_ONE_CLEAR] ##1
        (!clr_ff[`EWK_CL_EXT_IRQ_ONE_CLEAR] && (flag[0] == $past(evt[0]))))
        else $error("interrupt 1 clear misbehaved");
    rx_clr_a: assert property ((clr_ff[`EWK_CL_RX] && !evt[2]) |=> !flag[2])
        else $error("serial wake flag not cleared");
    ext_irq_three_clear_clr_a: assert property ((clr_ff[`EWK_CL_EXT_IRQ_THREE_CLEAR] && !evt[1]) |=> !flag[1])
        else $error("interrupt 3 flag not cleared");
    ro_stat_a: assert property (
        (wr_go && avs_address_in == `EWK_ADDR_STAT && !evt[0]) |=> $stable(flag[0]))
        else $error("status write changed a flag");
    zero_wr_a: assert property (
        (wr_go && avs_address_in == `EWK_ADDR_CLR && avs_writedata_in == `EWK_ZERO32)
        |=> clr_ff == `EWK_ZERO32 ##1 (flag | ~$past(flag)) == '1)
        else $error("zero clear write cleared a flag");
    ext_irq_three_clear_valid_a: assert property (!evt_if[1].level |-> !stat_rd[`EWK_ST_EXT_IRQ_THREE_CLEAR])
        else $error("bit 3 shown without inter-die line");
    nmi_clr_a: assert property ((nmiclr_ff && nmi_flag_ff && !(nmi_s2_ff && !nmi_prev_ff))
        |=> !nmi_flag_ff)
        else $error("pending NMI not cleared");
    afe_wake_a: assert property (die_access_in |=>
        afe_wake_out == $past(aien_ff[`EWK_AIEN_WAKE]))
        else $error("front-end wake does not follow enable");
    bus_ack_a: assert property (avs_waitrequest_out |=> (go -> !avs_waitrequest_out))
        else $error("access stalled more than one cycle");
endmodule : ewk_top

// file: tb/ewk_pin_model.sv
`timescale 1ns/1ns
module ewk_pin_model (
    input  wire logic       sys_clk_in,  // Core clock
    input  wire logic       nrst_in,     // Sync reset, active low
    input  wire logic [3:0] lvl_in,      // Wanted levels
    output logic            wake_out,    // System wake pin
    output logic            rx_out,      // Serial receive pin
    output logic            die_irq_out, // Inter-die line
    output logic            nmi_out      // NMI level
);
    // Levels move only on an edge, so each holds a whole cycle
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            {nmi_out, die_irq_out, rx_out, wake_out} <= 4'h2;
        end else begin
            {nmi_out, die_irq_out, rx_out, wake_out} <= lvl_in;
        end
    end
endmodule : ewk_pin_model

// file: tb/ewk_top_bench.sv
`timescale 1ns/1ns
`include "ewk_params.svh"
module ewk_top_bench;
    localparam logic [31:0] CFG = `EWK_ADDR_CFG;
    localparam logic [31:0] STAT = `EWK_ADDR_STAT;
    localparam logic [31:0] CLR = `EWK_ADDR_CLR;
    localparam logic [31:0] NCLR = `EWK_ADDR_NMICLR;
    localparam logic [31:0] AIEN = `EWK_ADDR_AIEN;
    localparam logic [31:0] ISTAT = `EWK_ADDR_ISTAT;
    localparam logic [31:0] IMASK = `EWK_ADDR_IMASK;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        die_acc = 1'b0;
    logic [3:0]  lvl = 4'h2;
    logic        wait_rq, wake_pin, rx_pin, die_irq, nmi, afe_wake, nmi_pend, irq;
    logic        idle, lvl_mode, exp_wake;
    int          n_mismatch = 0;
    int          checks = 0;
    int          seed = 91137;
    int          r;

    always #5 clk = ~clk;

    ewk_pin_model i_ewk_pin_model (.sys_clk_in(clk), .nrst_in(nrst), .lvl_in(lvl),
        .wake_out(wake_pin), .rx_out(rx_pin), .die_irq_out(die_irq), .nmi_out(nmi));
    ewk_top i_ewk_top (.sys_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
        .system_wake_pin_in(wake_pin), .serial_receive_pin_in(rx_pin),
        .inter_die_interrupt_in(die_irq), .nmi_in(nmi), .die_access_in(die_acc),
        .afe_wake_out(afe_wake), .nmi_pending_out(nmi_pend), .irq_out(irq));

    task summarize();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Holds the request until waitrequest is seen low, giving up after 100 cycles
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 100);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 100) n_mismatch++;
    endtask : bus

    task rchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(v, e);
    endtask : rchk

    // Synchroniser plus trigger take about four edges; eight is margin
    task pin(input int idx, input logic val);
        @(posedge clk);
        lvl[idx] <= val;
        repeat (8) @(posedge clk);
    endtask : pin

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task note(input string s);
        $display("test %s done", s);
    endtask : note

    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rchk(CFG, 32'h00200000);
        rchk(STAT, 32'h0);
        rchk(CLR, 32'h0);
        rchk(NCLR, 32'h0);
        rchk(AIEN, 32'h0);
        rchk(32'h4004C088, 32'h0);
        note("reset");
        bus(1'b1, CFG, 32'h00000080);
        pin(0, 1'b1);
        rchk(STAT, 32'h2);
        check(irq, 1'b0);
        bus(1'b1, IMASK, 32'h2);
        cyc(2);
        check(irq, 1'b1);
        bus(1'b1, STAT, 32'hFFFFFFFF);
        rchk(STAT, 32'h2);
        bus(1'b1, CLR, 32'h0);
        rchk(STAT, 32'h2);
        bus(1'b1, CLR, 32'h2);
        rchk(STAT, 32'h0);
        rchk(CLR, 32'h0);
        check(irq, 1'b1);
        bus(1'b1, ISTAT, 32'h2);
        cyc(3);
        check(irq, 1'b0);
        pin(0, 1'b0);
        note("ext_irq_one_clear");
        for (int m = 0; m < 8; m++) begin
            idle = (m == 1 || m == 4 || m == 5);
            lvl_mode = (m == 3 || m == 4 || m == 7);
            pin(1, idle);
            bus(1'b1, CFG, {8'h0, m[2:0], 1'b1, 20'h0});
            cyc(6);
            bus(1'b1, CLR, 32'h20);
            rchk(STAT, 32'h0);
            pin(1, !idle);
            rchk(STAT, 32'h20);
            bus(1'b1, STAT, 32'h0);
            rchk(STAT, 32'h20);
            if (lvl_mode) begin
                bus(1'b1, CLR, 32'h20);
                rchk(STAT, 32'h20);
            end
            pin(1, idle);
            bus(1'b1, CLR, 32'h20);
            rchk(STAT, 32'h0);
        end
        bus(1'b1, CFG, 32'h0);
        pin(1, 1'b0);
        pin(1, 1'b1);
        rchk(STAT, 32'h0);
        note("serial");
        bus(1'b1, CFG, 32'h00008000);
        pin(2, 1'b1);
        rchk(STAT, 32'h8);
        pin(2, 1'b0);
        rchk(STAT, 32'h0);
        bus(1'b1, CFG, 32'h0);
        pin(2, 1'b1);
        rchk(STAT, 32'h8);
        bus(1'b1, CLR, 32'h10);
        rchk(STAT, 32'h0);
        pin(2, 1'b0);
        note("ext_irq_three_clear");
        pin(3, 1'b1);
        check(nmi_pend, 1'b1);
        bus(1'b1, NCLR, 32'h1);
        cyc(2);
        check(nmi_pend, 1'b0);
        rchk(NCLR, 32'h0);
        pin(3, 1'b0);
        note("nmi");
        bus(1'b1, AIEN, 32'h0000FFF8);
        rchk(AIEN, 32'h8);
        for (int k = 1; k >= 0; k--) begin
            die_acc <= 1'b0;
            bus(1'b1, AIEN, {28'h0, k[0], 3'h0});
            exp_wake = 1'b0;
            repeat (200) begin
                @(posedge clk);
                r = $random(seed);
                die_acc <= r[0];
                // Sample after the launching edge has settled
                #1;
                check(afe_wake, exp_wake);
                exp_wake = die_acc & k[0];
            end
        end
        note("wake");
        summarize();
    end
endmodule : ewk_top_bench
